/* verification/cdsp_dsp_model.sv */
`timescale 1ns/1ps
module cdsp_dsp_model
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic ofs_i,
    input wire logic sdo_i,
    input wire logic go_i,
    input wire logic direct_i,
    input wire logic [15:0] word_i,
    output logic sdi_o,
    output logic sifs_o,
    output logic [15:0] rx_word_o,
    output int rx_count_o
);
    logic sclk_d;
    logic [4:0] tcnt, rcnt;
    logic [15:0] nxt, tsh, rsh;
    // dsp port acts on bit clock edges as seen from the core clock
    always @(posedge core_clk_i)
    begin
        sclk_d <= sclk_i;
        if (rst_i)
        begin
            tcnt <= 5'h0;
            rcnt <= 5'h0;
            sifs_o <= 1'b0;
            sdi_o <= 1'b0;
            rx_count_o <= 0;
        end
        else if (sclk_i && !sclk_d)
        begin
            // own sync leads by one clock or rides on the last bit
            sifs_o <= !direct_i && go_i && !sifs_o && tcnt <= 5'h1;
            // word latched with its own sync so a later request cannot overtake it
            if (!direct_i && go_i && !sifs_o && tcnt <= 5'h1)
                nxt <= word_i;
            // direct wiring: input words ride on the codec's own output sync
            if (direct_i ? (ofs_i && go_i) : sifs_o)
            begin
                sdi_o <= direct_i ? word_i[15] : nxt[15];
                tsh <= direct_i ? {word_i[14:0], 1'b0} : {nxt[14:0], 1'b0};
                tcnt <= 5'hf;
            end
            else if (tcnt != 5'h0)
            begin
                sdi_o <= tsh[15];
                tsh <= {tsh[14:0], 1'b0};
                tcnt <= tcnt - 5'h1;
            end
            else
                sdi_o <= ~sdi_o; // idle line never holds a stale bit
        end
        else if (!sclk_i && sclk_d)
        begin
            // receive side samples on the falling bit clock
            if (rcnt != 5'h0)
            begin
                rsh <= {rsh[14:0], sdo_i};
                rcnt <= rcnt - 5'h1;
            end
            if (rcnt == 5'h1)
            begin
                rx_word_o <= {rsh[14:0], sdo_i};
                rx_count_o <= rx_count_o + 1;
            end
            if (ofs_i)
                rcnt <= 5'h10;
        end
    end
endmodule : cdsp_dsp_model

/* verification/cdsp_serial_port_bench.sv */
`timescale 1ns/1ps
module cdsp_serial_port_bench;
    import cdsp_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic direct = 1'b0;
    logic [15:0] txw = 16'h0;
    logic [31:0] rdata;
    logic [31:0] seed = 32'hcd0a162c;
    logic sclk, serial_input_line, sifs, serial_output_line, ofs, upd, analog_loopback;
    logic [15:0] dac, rxw;
    int rxn, nupd, num_errors, n_compared, cyc;

    cdsp_serial_port dut_u
    (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sclk_o(sclk),
        .serial_input_line_i(serial_input_line), .input_frame_sync_i(direct ? ofs : sifs),
        .serial_output_line_o(serial_output_line),
        .output_frame_sync_o(ofs), .dac_data_o(dac), .dac_update_o(upd),
        .analog_loopback_o(analog_loopback)
    );
    cdsp_dsp_model dsp_u
    (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .sclk_i(sclk), .ofs_i(ofs), .sdo_i(serial_output_line),
        .go_i(go), .direct_i(direct), .word_i(txw), .sdi_o(serial_input_line), .sifs_o(sifs), .rx_word_o(rxw),
        .rx_count_o(rxn)
    );

    always #20 core_clk_i = ~core_clk_i;

    // update pulses counted, and a ceiling on the whole run
    always @(posedge core_clk_i)
    begin
        nupd += (upd === 1'b1);
        cyc++;
        if (cyc == 90000)
        begin
            num_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic summarize();
        if (num_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask : wrr

    // read data is looked at in the one cycle where it stands
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask : rdc

    task automatic next_frame();
        int c;
        c = rxn;
        while (rxn == c)
            @(posedge core_clk_i);
    endtask : next_frame

    // hold the request until the dsp sync has gone out with it
    task automatic send(input logic [15:0] w, input logic more);
        @(posedge core_clk_i);
        txw <= w;
        go <= 1'b1;
        while (sifs === 1'b1)
            @(posedge core_clk_i);
        while (sifs !== 1'b1)
            @(posedge core_clk_i);
        go <= more;
    endtask : send

    task automatic ctl(input logic [2:0] rg, input logic [7:0] d);
        next_frame();
        send({1'b1, 1'b0, 3'h0, rg, d}, 1'b0);
        repeat (150) @(posedge core_clk_i);
    endtask : ctl

    initial
    begin
        logic [15:0] a, w0, w1, e;
        int u;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // read-only and unmapped places stay zero
        wrr(ADDR_DAC, 32'h1234);
        rdc(ADDR_DAC, 32'h0);
        rdc(ADDR_PRIMARY, 32'h0);
        rdc(ADDR_SIXTH, 32'h0);
        rdc(ADDR_STATUS, 32'h0);
        rdc(8'h20, 32'h0);
        a = 16'(rnd());
        wrr(ADDR_ADC, 32'(a));
        rdc(ADDR_ADC, 32'(a));
        // program mode: a word for a later device leaves decremented
        next_frame();
        send(16'h9580, 1'b0);
        next_frame();
        check(32'(rxw), 32'h8d80);
        rdc(ADDR_SIXTH, 32'h0);
        next_frame();
        check(32'(rxw), 32'(a));
        ctl(REG_PRIMARY, 8'h03);
        rdc(ADDR_STATUS, 32'h1);
        next_frame();
        check(32'(rxw), {17'h0, a[14:0]});
        // two back-to-back data words, cascade length one then two, inside one interval
        // two units of sixteen bits stay well inside 256 serial clocks
        for (int k = 0; k < 2; k++)
        begin
            ctl(REG_PRIMARY, 8'h03 | 8'(k << 4));
            next_frame();
            u = nupd;
            w0 = {1'b0, 15'(rnd())};
            w1 = {1'b0, 15'(rnd())};
            send(w0, 1'b1);
            send(w1, 1'b0);
            repeat (300) @(posedge core_clk_i);
            e = (k == 0) ? {w0[14:0], 1'b0} : {w1[14:0], 1'b0};
            check(32'(dac), 32'(e));
            check(nupd - u, 32'h1);
            rdc(ADDR_DAC, 32'(e));
        end
        ctl(REG_PRIMARY, 8'h07);
        a = 16'(rnd());
        wrr(ADDR_ADC, 32'(a));
        next_frame();
        next_frame();
        check(32'(dac), 32'(a));
        ctl(REG_PRIMARY, 8'h03);
        send(16'h2222, 1'b0);
        repeat (150) @(posedge core_clk_i);
        check(32'(dac), 32'h4444);
        // serial loop-back echoes the input frame, then is cleared
        ctl(REG_PRIMARY, 8'h0b);
        w0 = {1'b0, 15'(rnd())};
        send(w0, 1'b0);
        next_frame();
        check(32'(rxw), 32'(w0));
        send(16'h8003, 1'b0);
        repeat (400) @(posedge core_clk_i);
        next_frame();
        check(32'(rxw), {17'h0, a[14:0]});
        ctl(REG_SIXTH, 8'h80);
        check(32'(analog_loopback), 32'h1);
        rdc(ADDR_SIXTH, 32'h80);
        ctl(REG_POWER, 8'h02);
        check(32'(analog_loopback), 32'h0);
        ctl(REG_SIXTH, 8'h80);
        check(32'(analog_loopback), 32'h0);
        ctl(REG_PRIMARY, 8'h80);
        rdc(ADDR_PRIMARY, 32'h0);
        ctl(REG_PRIMARY, 8'h01);
        rdc(ADDR_STATUS, 32'h2);
        next_frame();
        w0 = 16'h8000 | 16'(rnd());
        send(w0, 1'b0);
        repeat (150) @(posedge core_clk_i);
        check(32'(dac), 32'(w0));
        // direct wiring: control word preloaded before the codec leaves reset
        rst_i <= 1'b1;
        direct <= 1'b1;
        txw <= 16'h0001;
        go <= 1'b1;
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        next_frame();
        rdc(ADDR_STATUS, 32'h2);
        w0 = 16'(rnd());
        txw <= w0;
        next_frame();
        next_frame();
        check(32'(dac), 32'(w0));
        summarize();
    end
endmodule : cdsp_serial_port_bench

/* verification/cdsp_serial_port_monitor.sv */
`timescale 1ns/1ps
module cdsp_serial_port_monitor
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic sclk_o,
    input wire logic serial_output_line_o,
    input wire logic output_frame_sync_o,
    input wire logic [15:0] dac_data_o,
    input wire logic dac_update_o
);
    wire ofs = output_frame_sync_o;
    wire serial_output_line = serial_output_line_o;
    default clocking mon_cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // bit clock halves of four core clocks
    sequence sclk_hi_s;
        sclk_o [*4];
    endsequence
    sequence sclk_lo_s;
        !sclk_o [*4];
    endsequence
    // frame sync and serial data outputs move one core clock after a bit clock rise, never mid-bit
    sequence after_rise_s;
        $past(sclk_o) && !$past(sclk_o, 2);
    endsequence
    AST_SCLK_PERIOD: assert property ($rose(sclk_o) |-> sclk_hi_s ##1 sclk_lo_s ##1 sclk_o)
        else $error("bit clock period wrong");
    AST_OFS_WIDTH: assert property ($rose(ofs) |-> ofs [*8] ##1 !ofs)
        else $error("frame sync width wrong");
    AST_OFS_ALIGN: assert property ($rose(ofs) |-> after_rise_s)
        else $error("frame sync off the bit clock");
    AST_OFS_GAP: assert property ($fell(ofs) |-> !ofs [*8])
        else $error("frame sync inside a word");
    AST_SDO_ALIGN: assert property ($changed(serial_output_line) |-> after_rise_s)
        else $error("data moved off the bit clock");
    AST_DAC_PULSE: assert property (dac_update_o |=> !dac_update_o)
        else $error("dac update too long");
    AST_DAC_CAUSE: assert property ($changed(dac_data_o) |-> dac_update_o)
        else $error("dac moved without update");
    AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data without a read");
endmodule : cdsp_serial_port_monitor

bind cdsp_serial_port cdsp_serial_port_monitor mon_u
(
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .sclk_o(sclk_o), .serial_output_line_o(serial_output_line_o),
    .output_frame_sync_o(output_frame_sync_o), .dac_data_o(dac_data_o),
    .dac_update_o(dac_update_o)
);

/* verilog/cdsp_pkg.sv */
package cdsp_pkg;

    // serial clock derived from the core clock by a fixed divider
    localparam int CORE_CLK_MHZ = 25;
    localparam int SCLK_PERIOD_NS = 320;
    localparam int SCLK_DIV = SCLK_PERIOD_NS * CORE_CLK_MHZ / 1000;
    localparam logic [2:0] SCLK_HALF_M1 = 3'(SCLK_DIV / 2 - 1);

    // word framing
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] WORD_LAST = 5'h0f;
    // sample interval in serial clocks, minus one (256 sclk = 2048 core clocks)
    localparam logic [7:0] SAMPLE_SCLKS_M1 = 8'hff;

    // primary control register fields
    localparam int CRA_DPS = 0;
    localparam int CRA_MM = 1;
    localparam int CRA_DLB = 2;
    localparam int CRA_SLB = 3;
    localparam int CRA_DC_LSB = 4;
    localparam int CRA_RESET = 7;
    // power control and sixth control register fields
    localparam int CRC_AGT = 1;
    localparam int CRF_ALB = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // control word layout
    localparam int CW_FLAG = 15;
    localparam int CW_DEV_LSB = 11;
    localparam int CW_REG_LSB = 8;
    localparam logic [2:0] REG_PRIMARY = 3'h0;
    localparam logic [2:0] REG_POWER = 3'h2;
    localparam logic [2:0] REG_SIXTH = 3'h5;

    // software register port byte offsets
    localparam logic [7:0] ADDR_ADC = 8'h00;
    localparam logic [7:0] ADDR_DAC = 8'h04;
    localparam logic [7:0] ADDR_PRIMARY = 8'h08;
    localparam logic [7:0] ADDR_POWER = 8'h0c;
    localparam logic [7:0] ADDR_SIXTH = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    typedef struct packed {
        logic [2:0] div;
        logic sclk;
        logic rise;
        logic fall;
        logic [7:0] samp_cnt;
        logic [4:0] tx_cnt;
        logic [15:0] tx_shift;
        logic ofs;
        logic serial_output_line;
        logic [15:0] adc_reg;
        logic [15:0] dac_reg;
        logic dac_upd;
        logic [15:0] pass_word;
        logic pass_pending;
        logic [2:0] frame_idx;
        logic [7:0] primary_control_register;
        logic [7:0] crc;
        logic [7:0] sixth_control_register;
        logic [31:0] rdata;
    } cdsp_core_s;

    typedef struct packed {
        logic d_s1;
        logic d_s2;
        logic f_s1;
        logic f_s2;
        logic busy;
        logic [4:0] cnt;
        logic [15:0] shift;
        logic [15:0] word;
        logic valid;
        logic [15:0] lb_fs_sr;
        logic [15:0] lb_d_sr;
    } cdsp_rx_s;

    function automatic logic cdsp_is_mixed(input logic [7:0] primary_control_register);
        cdsp_is_mixed = primary_control_register[CRA_DPS] & primary_control_register[CRA_MM];
    endfunction : cdsp_is_mixed

    function automatic logic cdsp_is_data(input logic [7:0] primary_control_register);
        cdsp_is_data = primary_control_register[CRA_DPS] & ~primary_control_register[CRA_MM];
    endfunction : cdsp_is_data

endpackage : cdsp_pkg

/* verilog/cdsp_rx.sv */
`timescale 1ns/1ps
module cdsp_rx
    import cdsp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic serial_input_line_i,
    input wire logic input_frame_sync_i,
    cdsp_rx_if.rx link
);
    cdsp_rx_s s_reg;
    cdsp_rx_s s_next;

    // pins come from the far party, so two flops before any use
    always_comb
    begin
        s_next = s_reg;
        s_next.valid = 1'b0;
        s_next.d_s1 = serial_input_line_i;
        s_next.d_s2 = s_reg.d_s1;
        s_next.f_s1 = input_frame_sync_i;
        s_next.f_s2 = s_reg.f_s1;
        if (link.fall)
        begin
            // sixteen-stage delay of sync and data for serial loop-back
            s_next.lb_fs_sr = {s_reg.lb_fs_sr[14:0], s_reg.f_s2}; // RQ8
            s_next.lb_d_sr = {s_reg.lb_d_sr[14:0], s_reg.d_s2}; // RQ8
            // msb first, one bit per serial clock
            if (s_reg.busy)
            begin
                s_next.shift = {s_reg.shift[14:0], s_reg.d_s2}; // RQ26
                s_next.cnt = s_reg.cnt + 5'h01;
                if (s_reg.cnt == WORD_LAST)
                begin
                    s_next.valid = 1'b1;
                    s_next.word = {s_reg.shift[14:0], s_reg.d_s2};
                    s_next.busy = 1'b0;
                end
            end
            // sync seen one clock ahead; may overlap the last bit
            if (s_reg.f_s2)
            begin
                s_next.busy = 1'b1; // RQ12
                s_next.cnt = 5'h00;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign link.word_valid = s_reg.valid;
    assign link.word = s_reg.word;
    assign link.lb_fs = s_reg.lb_fs_sr[15];
    assign link.lb_bit = s_reg.lb_d_sr[15];
endmodule : cdsp_rx

/* verilog/cdsp_rx_if.sv */
`timescale 1ns/1ps
interface cdsp_rx_if;
    logic fall;
    logic word_valid;
    logic [15:0] word;
    logic lb_fs;
    logic lb_bit;

    modport core (output fall, input word_valid, input word, input lb_fs, input lb_bit);
    modport rx (input fall, output word_valid, output word, output lb_fs, output lb_bit);
endinterface : cdsp_rx_if

/* verilog/cdsp_serial_port.sv */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Function
// RQ1: mixed frame msb flags data or control
// RQ2: mixed data loads left-justified, lsb zero
// RQ3: mixed mode when both select bits set
// RQ4: mixed mode clears adc sample msb
// RQ5: mixed entry straight from first control word
// RQ6: digital loop-back copies adc into dac
// RQ7: digital loop-back cleared only in mixed
// RQ8: serial loop-back echoes sync and data
// RQ9: serial loop-back cleared only in mixed
// RQ10: sixth register bit seven enables analog loop-back
// RQ11: analog loop-back needs gain tap off
// RQ12: syncs lead the word by one clock
// RQ13: device drives the serial bit clock
// RQ14: indirect wiring: dsp makes input sync
// RQ15: direct wiring: output sync drives both
// RQ16: dsp preloads first word before reset release
// RQ17: cascade holds at most eight units
// RQ18: units times sixteen times rate within sclk
// RQ19: indirect cascade transfers fit sample interval
// RQ20: output word ends sixteen clocks after sample
// RQ21: count input syncs to pick dac frame
// RQ22: cascade count is length minus one
// RQ23: program word address zero accepted, else forwarded
// RQ24: data mode treats all frames as dac
// RQ25: flag one control, flag zero data
// RQ26: msb first, sixteen clocks per word
module cdsp_serial_port
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic sclk_o,
    input wire logic serial_input_line_i,
    input wire logic input_frame_sync_i,
    output logic serial_output_line_o,
    output logic output_frame_sync_o,
    output logic [15:0] dac_data_o,
    output logic dac_update_o,
    output logic analog_loopback_o
);
    import cdsp_pkg::*;

    cdsp_core_s s_reg;
    cdsp_core_s s_next;
    cdsp_rx_if rx_link ();

    // accept or forward one control word; program and mixed modes share it
    function automatic cdsp_core_s apply_ctrl(input cdsp_core_s st, input logic [15:0] w);
        cdsp_core_s r;
        logic [2:0] dev;
        logic [7:0] v;
        logic mixed_now;
        r = st;
        dev = w[CW_DEV_LSB +: 3];
        v = w[7:0];
        mixed_now = cdsp_is_mixed(st.primary_control_register);
        if (dev != 3'h0)
        begin
            // not ours: pass it on with the address one lower
            r.pass_word = w;
            r.pass_word[CW_DEV_LSB +: 3] = dev - 3'h1; // RQ23
            r.pass_pending = 1'b1; // RQ23
        end
        else
        begin
            unique case (w[CW_REG_LSB +: 3])
                REG_PRIMARY:
                begin
                    if (v[CRA_RESET])
                    begin
                        // software reset returns every control register to zero
                        r.primary_control_register = CTRL_RESET;
                        r.crc = CTRL_RESET;
                        r.sixth_control_register = CTRL_RESET;
                        r.pass_pending = 1'b0;
                        r.frame_idx = 3'h0;
                    end
                    else
                    begin
                        // first control word may enter mixed mode directly
                        r.primary_control_register = v; // RQ5 RQ3
                        // loop-backs can be set anywhere but dropped only in mixed
                        r.primary_control_register[CRA_DLB] = v[CRA_DLB] | (st.primary_control_register[CRA_DLB] & ~mixed_now); // RQ7
                        r.primary_control_register[CRA_SLB] = v[CRA_SLB] | (st.primary_control_register[CRA_SLB] & ~mixed_now); // RQ9
                    end
                end
                REG_POWER:
                begin
                    r.crc = v;
                    // powering the gain tap forces analog loop-back off
                    if (v[CRC_AGT])
                        r.sixth_control_register[CRF_ALB] = 1'b0; // RQ11
                end
                REG_SIXTH:
                begin
                    r.sixth_control_register = v;
                    r.sixth_control_register[CRF_ALB] = v[CRF_ALB] & ~st.crc[CRC_AGT]; // RQ10 RQ11
                end
                default:
                begin
                    // other registers are not held by this block
                    r.primary_control_register = st.primary_control_register;
                end
            endcase
        end
        apply_ctrl = r;
    endfunction : apply_ctrl

    // dac frame selection by counting input frames against the cascade count
    function automatic cdsp_core_s take_dac(input cdsp_core_s st, input logic [15:0] d);
        cdsp_core_s r;
        r = st;
        // loop-back owns the dac while it is on
        if ((st.frame_idx == st.primary_control_register[CRA_DC_LSB +: 3]) && !st.primary_control_register[CRA_DLB]) // RQ21 RQ22
        begin
            r.dac_reg = d;
            r.dac_upd = 1'b1;
        end
        // counter stops at the eighth unit, the longest cascade
        if (st.frame_idx != 3'h7) // RQ17
            r.frame_idx = st.frame_idx + 3'h1; // RQ21
        take_dac = r;
    endfunction : take_dac

    // next-state logic for the whole port
    always_comb
    begin
        s_next = s_reg;
        s_next.dac_upd = 1'b0;
        s_next.rdata = 32'h0000_0000;
        s_next.rise = 1'b0;
        s_next.fall = 1'b0;

        // bit clock made here and driven out
        if (s_reg.div == SCLK_HALF_M1)
        begin
            s_next.div = 3'h0;
            s_next.sclk = ~s_reg.sclk; // RQ13
            s_next.rise = ~s_reg.sclk;
            s_next.fall = s_reg.sclk;
        end
        else
        begin
            s_next.div = s_reg.div + 3'h1;
        end

        // transmit side advances on the serial clock rising edge
        if (s_reg.rise)
        begin
            if (s_reg.samp_cnt == 8'h00)
            begin
                // sample event: sync now, word follows over the next sixteen clocks
                s_next.samp_cnt = SAMPLE_SCLKS_M1;
                s_next.ofs = 1'b1; // RQ12
                s_next.serial_output_line = 1'b0;
                s_next.tx_cnt = WORD_BITS; // RQ20
                s_next.frame_idx = 3'h0;
                if (s_reg.pass_pending)
                begin
                    s_next.tx_shift = s_reg.pass_word; // RQ23
                    s_next.pass_pending = 1'b0;
                end
                else if (cdsp_is_mixed(s_reg.primary_control_register))
                    s_next.tx_shift = {1'b0, s_reg.adc_reg[14:0]}; // RQ4
                else
                    s_next.tx_shift = s_reg.adc_reg;
                if (s_reg.primary_control_register[CRA_DLB])
                begin
                    s_next.dac_reg = s_reg.adc_reg; // RQ6
                    s_next.dac_upd = 1'b1;
                end
            end
            else
            begin
                s_next.samp_cnt = s_reg.samp_cnt - 8'h01;
                s_next.ofs = 1'b0;
                if (s_reg.tx_cnt != 5'h00)
                begin
                    s_next.serial_output_line = s_reg.tx_shift[15]; // RQ26
                    s_next.tx_shift = {s_reg.tx_shift[14:0], 1'b0};
                    s_next.tx_cnt = s_reg.tx_cnt - 5'h01; // RQ20
                end
                else
                    s_next.serial_output_line = 1'b0;
            end
            // serial loop-back replaces the normal output stream
            if (s_reg.primary_control_register[CRA_SLB])
            begin
                s_next.ofs = rx_link.lb_fs; // RQ8
                s_next.serial_output_line = rx_link.lb_bit; // RQ8
            end
        end

        // received word handling by mode
        if (rx_link.word_valid)
        begin
            if (!s_reg.primary_control_register[CRA_DPS])
                s_next = apply_ctrl(s_next, rx_link.word); // RQ23
            else if (cdsp_is_mixed(s_reg.primary_control_register))
            begin
                if (rx_link.word[CW_FLAG]) // RQ1 RQ25
                    s_next = apply_ctrl(s_next, rx_link.word);
                else
                    s_next = take_dac(s_next, {rx_link.word[14:0], 1'b0}); // RQ2
            end
            else if (cdsp_is_data(s_reg.primary_control_register))
                // frozen configuration until reset
                s_next = take_dac(s_next, rx_link.word); // RQ24
        end

        // software register port, read data valid the cycle after the strobe
        if (reg_wr_i && (reg_addr_i == ADDR_ADC))
            s_next.adc_reg = reg_wdata_i[15:0];
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                ADDR_ADC: s_next.rdata = {16'h0000, s_reg.adc_reg};
                ADDR_DAC: s_next.rdata = {16'h0000, s_reg.dac_reg};
                ADDR_PRIMARY: s_next.rdata = {24'h00_0000, s_reg.primary_control_register};
                ADDR_POWER: s_next.rdata = {24'h00_0000, s_reg.crc};
                ADDR_SIXTH: s_next.rdata = {24'h00_0000, s_reg.sixth_control_register};
                ADDR_STATUS: s_next.rdata = {24'h00_0000, s_reg.pass_pending,
                    s_reg.frame_idx, 2'h0, cdsp_is_data(s_reg.primary_control_register), cdsp_is_mixed(s_reg.primary_control_register)};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register; pin reset clears every control register
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign rx_link.fall = s_reg.fall;

    cdsp_rx u_rx
    (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .serial_input_line_i(serial_input_line_i),
        .input_frame_sync_i(input_frame_sync_i),
        .link(rx_link)
    );

    // outputs straight from the state register
    assign reg_rdata_o = s_reg.rdata;
    assign sclk_o = s_reg.sclk;
    assign serial_output_line_o = s_reg.serial_output_line;
    assign output_frame_sync_o = s_reg.ofs;
    assign dac_data_o = s_reg.dac_reg;
    assign dac_update_o = s_reg.dac_upd;
    assign analog_loopback_o = s_reg.sixth_control_register[CRF_ALB]; // RQ10
endmodule : cdsp_serial_port
